// File: design/serial_status_ctrl.sv
// Status flags, interrupt levels and enables of a serial port, AXI4-Lite slave
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Receive-done flag high while unread characters sit in the receive store.
// - Receiver off flushes the store, clearing receive-done and error flags.
// - Writing one to status bit 7 clears receive-done.
// - Transmit-done sets when the last bit left and no character waits.
// - Transmit-done clears on vector taken or on write-one to its bit.
// - Buffer-empty flag is one when transmit buffer empty, else zero.
// - Buffer-empty flag is set after reset.
// - Writing the data location clears the buffer-empty flag.
// - Receive-done request repeats while the flag stays set.
// - Framing fault set when first stop bit of head character is zero, until read.
// - Overrun set when store full, shifter full and new start bit arrives.
// - Parity fault shown for head character only while checking is on.
// - Error flags read zero in master SPI mode.
// - Status bit 1 always reads zero.
// - Status bit 0 shows the ninth received bit of the head character.
// - Three two-bit levels; each enabled request follows its flag.
// - Control bit 4 enables receiver and takes over the receive pin.
// - Control bit 3 enables transmitter and takes over the transmit pin.
// - Transmitter shutdown waits until shifter and buffer are empty.
module serial_status_ctrl
  import serial_status_pkg::*;
#(
  parameter int FRAME_CYCLES = 10
) (
  input wire logic CLK_SYS_I, // 40 MHz system clock
  input wire logic NRST_I, // Async reset, active low
  input wire logic [serial_status_pkg::ADDR_W-1:0] AWADDR_I, // Write address
  input wire logic AWVALID_I, // Write address valid
  output logic AWREADY_O, // Write address ready
  input wire logic [31:0] WDATA_I, // Write data
  input wire logic [3:0] WSTRB_I, // Write strobes
  input wire logic WVALID_I, // Write data valid
  output logic WREADY_O, // Write data ready
  output logic [1:0] BRESP_O, // Write response
  output logic BVALID_O, // Write response valid
  input wire logic BREADY_I, // Write response ready
  input wire logic [serial_status_pkg::ADDR_W-1:0] ARADDR_I, // Read address
  input wire logic ARVALID_I, // Read address valid
  output logic ARREADY_O, // Read address ready
  output logic [31:0] RDATA_O, // Read data
  output logic [1:0] RRESP_O, // Read response
  output logic RVALID_O, // Read data valid
  input wire logic RREADY_I, // Read data ready
  input wire logic RX_START_I, // Start bit seen on receive line, pulse
  input wire logic RX_CHAR_VALID_I, // Received character complete, pulse
  input wire logic [8:0] RX_CHAR_I, // Received character, nine bits
  input wire logic RX_STOP_BIT_I, // First stop bit of that character
  input wire logic RX_PARITY_BAD_I, // Parity check failed for that character
  input wire logic TX_VECTOR_TAKEN_I, // Transmit-done vector executed, pulse
  output logic TXD_O, // Serial transmit line
  output logic TXD_OE_O, // Transmitter owns the transmit pin
  output logic RXD_OWN_O, // Receiver owns the receive pin
  output logic [1:0] RXC_IRQ_O, // Receive-done request level
  output logic [1:0] TXC_IRQ_O, // Transmit-done request level
  output logic [1:0] DRE_IRQ_O // Buffer-empty request level
);
  import serial_status_pkg::*;

  initial begin
    if (FRAME_CYCLES < 2) $error("serial_status_ctrl: FRAME_CYCLES too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [ADDR_W-1:0] rd_addr;
  logic control_word_a_wr;
  logic control_word_b_wr;
  logic status_wr;
  logic data_wr;
  logic data_rd;

  assign AWREADY_O = !aw_held && !BVALID_O;
  assign WREADY_O = !w_held && !BVALID_O;
  assign ARREADY_O = !RVALID_O;
  assign wr_fire = aw_held && w_held && !BVALID_O;
  assign rd_fire = ARVALID_I && ARREADY_O;
  assign rd_addr = ARADDR_I;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == OFF_DATA || a == OFF_STATUS || a == OFF_LEVELS || a == OFF_ENABLE;
  endfunction

  assign data_wr = wr_fire && aw_addr == OFF_DATA && w_strb[0];
  assign status_wr = wr_fire && aw_addr == OFF_STATUS && w_strb[0];
  assign control_word_a_wr = wr_fire && aw_addr == OFF_LEVELS && w_strb[0];
  assign control_word_b_wr = wr_fire && aw_addr == OFF_ENABLE && w_strb[0];
  assign data_rd = rd_fire && rd_addr == OFF_DATA;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= {AWADDR_I[ADDR_W-1:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_held <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
    end else if (wr_fire) begin
      BVALID_O <= 1'b1;
      BRESP_O <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] control_word_a;
  logic [7:0] control_word_b;
  logic receiver_on;
  logic transmitter_on;
  logic parity_on;
  logic spi_mode;
  logic tx_active;

  assign receiver_on = control_word_b[BIT_RX_ON];
  assign transmitter_on = control_word_b[BIT_TX_ON];
  assign parity_on = control_word_b[BIT_PAR_ON];
  assign spi_mode = control_word_b[BIT_SPI_MODE];

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      control_word_a <= LEVELS_RESET;
      control_word_b <= ENABLE_RESET;
    end else begin
      if (control_word_a_wr) control_word_a <= {2'b00, w_data[5:0]};
      if (control_word_b_wr) control_word_b <= {3'b000, w_data[4:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  localparam int ENTRY_W = 11;
  logic [ENTRY_W-1:0] head;
  logic [1:0] rx_count;
  logic shifter_full;
  logic [ENTRY_W-1:0] shifter_entry;
  logic store_push;
  logic rx_overrun_flag;
  logic rx_done_flag;
  logic rx_flush;
  logic rxc_clear;

  assign rx_flush = !receiver_on || rxc_clear;
  assign rxc_clear = status_wr && w_data[BIT_RXC];
  assign store_push = shifter_full && (rx_count < 2'(RX_DEPTH) || data_rd);

  rx_char_store #(
    .WIDTH(ENTRY_W)
  ) u_store (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .flush_i(rx_flush),
    .push_i(store_push),
    .push_data_i(shifter_entry),
    .pop_i(data_rd),
    .head_o(head),
    .count_o(rx_count)
  );

  // One-character holding stage in front of the store
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shifter_full <= 1'b0;
      shifter_entry <= '0;
    end else if (!receiver_on) begin
      shifter_full <= 1'b0;
    end else if (RX_CHAR_VALID_I) begin
      shifter_full <= 1'b1;
      shifter_entry <= {!RX_STOP_BIT_I, RX_PARITY_BAD_I && parity_on, RX_CHAR_I};
    end else if (store_push) begin
      shifter_full <= 1'b0;
    end
  end

  assign rx_done_flag = rx_count != 2'd0;

  // Overrun sticks until the buffer is read; set wins over the read
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_overrun_flag <= 1'b0;
    end else if (rx_flush) begin
      rx_overrun_flag <= 1'b0;
    end else if (RX_START_I && rx_count == 2'(RX_DEPTH) && shifter_full) begin
      rx_overrun_flag <= 1'b1;
    end else if (data_rd) begin
      rx_overrun_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side
  tx_state_type tx_state;
  logic [7:0] tx_buf;
  logic tx_buffer_empty_flag;
  logic tx_done_flag;
  logic [9:0] tx_shift;
  logic [$clog2(FRAME_CYCLES+1)-1:0] tx_cnt;
  logic tx_pin_owned;
  logic tx_last_bit;

  assign tx_last_bit = tx_state == TX_SHIFT && tx_cnt == 1;

  // Buffer accepts a character only while empty
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_buf <= '0;
    end else if (data_wr && tx_buffer_empty_flag) begin
      tx_buffer_empty_flag <= 1'b0;
      tx_buf <= w_data[7:0];
    end else if (tx_state == TX_LOAD) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_state <= TX_IDLE;
      tx_shift <= '1;
      tx_cnt <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if ((transmitter_on || tx_pin_owned) && !tx_buffer_empty_flag) tx_state <= TX_LOAD;
        end
        TX_LOAD: begin
          tx_shift <= {1'b1, tx_buf[7:0], 1'b0};
          tx_cnt <= ($clog2(FRAME_CYCLES+1))'(FRAME_CYCLES);
          tx_state <= TX_SHIFT;
        end
        TX_SHIFT: begin
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_cnt <= tx_cnt - 1'b1;
          if (tx_cnt == 1) tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  assign tx_active = tx_state != TX_IDLE || !tx_buffer_empty_flag;

  // Set wins over both clears
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_done_flag <= 1'b0;
    end else if (tx_last_bit && tx_buffer_empty_flag) begin
      tx_done_flag <= 1'b1;
    end else if (TX_VECTOR_TAKEN_I || (status_wr && w_data[BIT_TXC])) begin
      tx_done_flag <= 1'b0;
    end
  end

  // Pin stays with the transmitter until pending work drains
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_pin_owned <= 1'b0;
    end else if (transmitter_on) begin
      tx_pin_owned <= 1'b1;
    end else if (!tx_active) begin
      tx_pin_owned <= 1'b0;
    end
  end

  assign TXD_O = tx_state == TX_SHIFT ? tx_shift[0] : 1'b1;
  assign TXD_OE_O = tx_pin_owned;
  assign RXD_OWN_O = receiver_on;

  ////////////////////////////////////////////////////////////////////////////
  // Status read-back and requests
  logic [7:0] status_value;

  always_comb begin
    status_value = 8'h00;
    status_value[BIT_RXC] = rx_done_flag;
    status_value[BIT_TXC] = tx_done_flag;
    status_value[BIT_DRE] = tx_buffer_empty_flag;
    status_value[BIT_FRAMING_FAULT_FLAG] = !spi_mode && rx_done_flag && head[10];
    status_value[BIT_OVF] = !spi_mode && rx_overrun_flag;
    status_value[BIT_PARITY_FAULT_FLAG] = !spi_mode && rx_done_flag && head[9] && parity_on;
    status_value[BIT_RSVD] = 1'b0;
    status_value[BIT_RX9] = rx_done_flag && head[8];
  end

  function automatic logic [1:0] gate_level(input logic flag, input logic [1:0] lvl);
    return flag ? lvl : 2'b00;
  endfunction

  assign RXC_IRQ_O = gate_level(rx_done_flag, control_word_a[LVL_RXC_LSB +: 2]);
  assign TXC_IRQ_O = gate_level(tx_done_flag, control_word_a[LVL_TXC_LSB +: 2]);
  assign DRE_IRQ_O = gate_level(tx_buffer_empty_flag, control_word_a[LVL_DRE_LSB +: 2]);

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= RESP_OKAY;
    end else if (rd_fire) begin
      RVALID_O <= 1'b1;
      RRESP_O <= is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      case (rd_addr)
        OFF_DATA: RDATA_O <= {24'h000000, head[7:0]};
        OFF_STATUS: RDATA_O <= {24'h000000, status_value};
        OFF_LEVELS: RDATA_O <= {24'h000000, control_word_a};
        OFF_ENABLE: RDATA_O <= {24'h000000, control_word_b};
        default: RDATA_O <= 32'h00000000;
      endcase
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rx_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !receiver_on |=> !rx_done_flag && !rx_overrun_flag)
    else $error("receive flags survive receiver disable");
  dre_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    data_wr && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
    else $error("data write did not clear buffer empty");
  txc_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    tx_last_bit && tx_buffer_empty_flag |=> tx_done_flag)
    else $error("transmit done not set after frame");
  txc_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    TX_VECTOR_TAKEN_I && !tx_last_bit |=> !tx_done_flag)
    else $error("transmit done not cleared by vector");
  tx_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    tx_active && tx_pin_owned |=> tx_pin_owned)
    else $error("transmit pin released while busy");
  irq_level_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (RXC_IRQ_O != 2'b00) == (rx_done_flag && control_word_a[5:4] != 2'b00))
    else $error("receive request mismatch");
  ovf_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    RX_START_I && rx_count == 2'd2 && shifter_full && receiver_on && !rxc_clear
    |=> rx_overrun_flag)
    else $error("overrun not flagged");
  rsvd_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !status_value[BIT_RSVD] && !(spi_mode && status_value[BIT_FRAMING_FAULT_FLAG]))
    else $error("reserved or SPI error bit nonzero");
  rxc_follow_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    rx_count != 2'd0 |-> status_value[BIT_RXC])
    else $error("receive done low with data");
endmodule

// File: design/serial_status_pkg.sv
// Register map, field positions and reset values of the serial status block
package serial_status_pkg;
  localparam int ADDR_W = 5;
  // Register index; each register is one aligned word at four times its index
  localparam int IDX_DATA = 0;
  localparam int IDX_STATUS = 1;
  localparam int IDX_LEVELS = 3;
  localparam int IDX_ENABLE = 4;
  localparam logic [ADDR_W-1:0] OFF_DATA = ADDR_W'(IDX_DATA * 4);
  localparam logic [ADDR_W-1:0] OFF_STATUS = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] OFF_LEVELS = ADDR_W'(IDX_LEVELS * 4);
  localparam logic [ADDR_W-1:0] OFF_ENABLE = ADDR_W'(IDX_ENABLE * 4);
  localparam int BIT_RXC = 7;
  localparam int BIT_TXC = 6;
  localparam int BIT_DRE = 5;
  localparam int BIT_FRAMING_FAULT_FLAG = 4;
  localparam int BIT_OVF = 3;
  localparam int BIT_PARITY_FAULT_FLAG = 2;
  localparam int BIT_RSVD = 1;
  localparam int BIT_RX9 = 0;
  localparam int BIT_RX_ON = 4;
  localparam int BIT_TX_ON = 3;
  localparam int BIT_PAR_ON = 0;
  localparam int BIT_SPI_MODE = 1;
  localparam int LVL_RXC_LSB = 4;
  localparam int LVL_TXC_LSB = 2;
  localparam int LVL_DRE_LSB = 0;
  localparam logic [7:0] LEVELS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int RX_DEPTH = 2;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SHIFT = 2'b11
  } tx_state_type;
endpackage

// File: design/rx_char_store.sv
// Two-entry store for received characters and their per-character status
`timescale 1ns/10ps
module rx_char_store #(
  parameter int WIDTH = 12
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic flush_i, // Drop all entries
  input wire logic push_i, // Write one entry
  input wire logic [WIDTH-1:0] push_data_i, // Entry written
  input wire logic pop_i, // Discard head entry
  output logic [WIDTH-1:0] head_o, // Head entry, registered
  output logic [1:0] count_o // Entries held
);
  logic [WIDTH-1:0] mem [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic do_push;
  logic do_pop;

  initial begin
    if (WIDTH < 1) $error("rx_char_store: WIDTH must be positive");
  end

  assign do_pop = pop_i && (count != 2'd0);
  assign do_push = push_i && (count != 2'd2 || do_pop);
  assign count_o = count;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else if (flush_i) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (do_push) wr_ptr <= ~wr_ptr;
      if (do_pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push) mem[wr_ptr] <= push_data_i;
  end

  // Head register follows the entry that will be at the read pointer next cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head_o <= '0;
    end else if (flush_i) begin
      head_o <= '0;
    end else if (do_pop && count == 2'd2) begin
      head_o <= mem[~rd_ptr];
    end else if (do_push && (count == 2'd0 || (do_pop && count == 2'd1))) begin
      head_o <= push_data_i;
    end
  end
endmodule

// File: dv/serial_far_model.sv
// Far-side serial device: feeds received characters and decodes the transmit line
`timescale 1ns/10ps
module serial_far_model (
  input wire logic clk_i, // System clock
  input wire logic txd_i, // Transmit line of the block
  output logic start_o, // Start bit seen, pulse
  output logic valid_o, // Character complete, pulse
  output logic [8:0] char_o, // Character bits
  output logic stop_o, // First stop bit
  output logic pbad_o // Parity failure
);
  logic [7:0] got[$];
  logic [7:0] sh;
  int bad_stop;
  int bit_n;

  initial begin
    start_o = 1'b0;
    valid_o = 1'b0;
    char_o = 9'h1AA;
    stop_o = 1'b0;
    pbad_o = 1'b1;
    bad_stop = 0;
    bit_n = -1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bit per cycle: start, eight data bits first bit lowest, stop
  always @(posedge clk_i) begin
    if (bit_n < 0) begin
      if (txd_i === 1'b0) bit_n <= 0;
    end else if (bit_n < 8) begin
      sh[bit_n[2:0]] <= txd_i;
      bit_n <= bit_n + 1;
    end else begin
      if (txd_i !== 1'b1) bad_stop <= bad_stop + 1;
      got.push_back(sh);
      bit_n <= -1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic start_only();
    @(posedge clk_i);
    start_o <= 1'b1;
    @(posedge clk_i);
    start_o <= 1'b0;
  endtask

  // Released lines show the inverse of the last value, never a stale copy
  task automatic send(input logic [8:0] c, input logic stp, input logic pb);
    start_only();
    repeat (3) @(posedge clk_i);
    valid_o <= 1'b1;
    char_o <= c;
    stop_o <= stp;
    pbad_o <= pb;
    @(posedge clk_i);
    valid_o <= 1'b0;
    char_o <= ~c;
    stop_o <= ~stp;
    pbad_o <= ~pb;
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the serial status block with a behavioural flag model
`timescale 1ns/10ps
module tb_top;
  import serial_status_pkg::*;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, vec_taken;
  logic awready, wready, bvalid, arready, rvalid, txd, txd_oe, rxd_own;
  logic rx_start, rx_valid, rx_stop, rx_pbad;
  logic [8:0] rx_char, c;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rxc_irq, txc_irq, dre_irq, r;
  logic [7:0] lvl, en, b, exp_tx[$];
  logic [7:0] modes[3] = '{8'h19, 8'h1B, 8'h18};
  logic ovf, txc, dre;
  int q[$];
  int n_mismatch, n_checks, i, k, seed;

  serial_status_ctrl #(.FRAME_CYCLES(10)) u_dut (.CLK_SYS_I(clk), .NRST_I(nrst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .RX_START_I(rx_start), .RX_CHAR_VALID_I(rx_valid),
    .RX_CHAR_I(rx_char), .RX_STOP_BIT_I(rx_stop), .RX_PARITY_BAD_I(rx_pbad),
    .TX_VECTOR_TAKEN_I(vec_taken), .TXD_O(txd), .TXD_OE_O(txd_oe), .RXD_OWN_O(rxd_own),
    .RXC_IRQ_O(rxc_irq), .TXC_IRQ_O(txc_irq), .DRE_IRQ_O(dre_irq));

  serial_far_model u_far (.clk_i(clk), .txd_i(txd), .start_o(rx_start), .valid_o(rx_valid),
    .char_o(rx_char), .stop_o(rx_stop), .pbad_o(rx_pbad));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    report_and_stop();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] rs);
    int j;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (j == 50) timeout();
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    int j;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (j == 50) timeout();
  endtask

  // Write one register and keep the flag model in step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [1:0] rs;
    axi_wr(a, {24'h0, d}, rs);
    chk("bresp", rs, RESP_OKAY);
    if (a == OFF_LEVELS) lvl = d;
    if (a == OFF_ENABLE) en = d;
    if ((a == OFF_ENABLE && !d[BIT_RX_ON]) || (a == OFF_STATUS && d[BIT_RXC])) begin
      q.delete();
      ovf = 1'b0;
    end
    if (a == OFF_STATUS && d[BIT_TXC]) txc = 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] rs;
    axi_rd(a, d, rs);
    chk("rdata", d, e);
    chk("rresp", rs, er);
  endtask

  // Status and the three request levels against the model
  task automatic chk_st();
    logic [31:0] d;
    logic [1:0] rs;
    logic [7:0] e, m;
    int h;
    axi_rd(OFF_STATUS, d, rs);
    h = (q.size() > 0) ? q[0] : 0;
    e = {q.size() > 0, txc, dre, 5'h00};
    if (q.size() > 0) begin
      e[BIT_FRAMING_FAULT_FLAG] = !h[9] && !en[BIT_SPI_MODE];
      e[BIT_PARITY_FAULT_FLAG] = h[10] && en[BIT_PAR_ON] && !en[BIT_SPI_MODE];
      e[BIT_RX9] = h[8];
    end
    e[BIT_OVF] = ovf && !en[BIT_SPI_MODE];
    m = (q.size() > 0) ? 8'hFF : 8'hFE;
    chk("status", d & {24'h0, m}, {24'h0, e & m});
    chk("rresp", rs, RESP_OKAY);
    chk("rxc_irq", rxc_irq, e[7] ? lvl[5:4] : 2'h0);
    chk("txc_irq", txc_irq, e[6] ? lvl[3:2] : 2'h0);
    chk("dre_irq", dre_irq, e[5] ? lvl[1:0] : 2'h0);
  endtask

  task automatic rd_data();
    int h;
    h = q.pop_front();
    rd_reg(OFF_DATA, h & 32'hFF, RESP_OKAY);
    ovf = 1'b0;
  endtask

  task automatic rx(input logic [8:0] ch, input logic s, input logic p);
    u_far.send(ch, s, p);
    q.push_back({p, s, ch});
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_txc();
    int j;
    for (j = 0; j < 100 && txc_irq !== lvl[3:2]; j++) @(posedge clk);
    if (j == 100) timeout();
    txc = 1'b1;
    dre = 1'b1;
    chk("tx_count", u_far.got.size(), exp_tx.size());
  endtask

  task automatic send_tx();
    b = 8'($urandom);
    wr(OFF_DATA, b);
    exp_tx.push_back(b);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, vec_taken} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {n_mismatch, n_checks} = '0;
    {lvl, en, ovf, txc} = '0;
    dre = 1'b1;
    seed = $urandom(66);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_st();
    rd_reg(OFF_LEVELS, LEVELS_RESET, RESP_OKAY);
    rd_reg(OFF_ENABLE, ENABLE_RESET, RESP_OKAY);
    rd_reg(5'h08, 32'h0, RESP_SLVERR);
    axi_wr(5'h14, 32'hFF, r);
    chk("bresp", r, RESP_SLVERR);
    wr(OFF_LEVELS, 8'h15 | 8'($urandom & 32'h2A));
    rd_reg(OFF_LEVELS, {24'h0, lvl}, RESP_OKAY);
    chk_st();
    wr(OFF_ENABLE, 8'h19);
    chk("rxd_own", rxd_own, 1'b1);
    @(posedge clk);
    chk("txd_oe", txd_oe, 1'b1);
    send_tx();
    send_tx();
    chk("dre_irq", dre_irq, 2'h0);
    wait_txc();
    chk_st();
    @(posedge clk);
    vec_taken <= 1'b1;
    @(posedge clk);
    vec_taken <= 1'b0;
    txc = 1'b0;
    chk_st();
    send_tx();
    wait_txc();
    wr(OFF_STATUS, 8'h40);
    chk_st();
    send_tx();
    send_tx();
    wr(OFF_ENABLE, 8'h11);
    @(posedge clk);
    chk("txd_oe", txd_oe, 1'b1);
    for (i = 0; i < 100 && txd_oe !== 1'b0; i++) @(posedge clk);
    if (i == 100) timeout();
    chk("tx_count", u_far.got.size(), exp_tx.size());
    txc = 1'b1;
    wr(OFF_LEVELS, lvl & 8'hFC);
    chk_st();
    foreach (modes[k]) begin
      wr(OFF_ENABLE, modes[k]);
      c = 9'($urandom);
      if (modes[k][BIT_SPI_MODE]) c[8] = 1'b0;
      rx(c, 1'b0, 1'b1);
      rx(c ^ 9'h0FF, 1'b1, 1'b0);
      chk_st();
      chk_st();
      rd_data();
      chk_st();
      rd_data();
      chk_st();
    end
    wr(OFF_ENABLE, 8'h19);
    for (k = 0; k < 3; k++) rx(9'($urandom), 1'b1, 1'b0);
    u_far.start_only();
    ovf = 1'b1;
    chk_st();
    rd_data();
    chk_st();
    wr(OFF_ENABLE, 8'h09);
    chk_st();
    chk("rxd_own", rxd_own, 1'b0);
    wr(OFF_ENABLE, 8'h19);
    rx(9'($urandom), 1'b0, 1'b1);
    wr(OFF_STATUS, 8'h80);
    chk_st();
    chk("stop_bits", u_far.bad_stop, 0);
    foreach (exp_tx[k]) chk("tx_byte", u_far.got[k], exp_tx[k]);
    report_and_stop();
  end
endmodule
